// File: hw/adc_config_register_bank.sv
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Burnout code selects off, 0.5, 2, 10 uA.
// - Bias bits enable midsupply on inputs zero, one.
// - Monitor bit 7 reports oscillator source, read-only.
// - Monitor field selects the converter input routing.
// - Non-normal monitor routing overrides the bias enables.
// - Reference and temperature monitor codes force gain one.
// - Gain register bits 6:4 hold amplifier gain.
// - Rate field selects 5 to 2000 samples/second.
// - Offset coefficient built from three bytes, LSB first.
// - Full-scale coefficient built from three bytes, LSB first.
// - Full-scale reloads factory trim on gain change.
// - Revision bits are read-only factory values.
// - Pin mode bit selects data-only or data-plus-ready.
// - Conversion end: pin falls, or pulses high first.
module adc_config_register_bank
    import adc_config_pkg::*;
#(
    parameter int REVISION_FIELD = 5,
    parameter logic [7:0][23:0] FULLSCALE_TRIM = {8{24'h400000}}
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic oscillator_external_i,
    input wire logic conversion_done_i,
    input wire logic [1:0] ready_release_i,
    input wire logic serial_data_i,
    input wire logic shift_active_i,
    input wire logic chip_select_active_i,
    output logic burnout_enable_o,
    output logic [2:0] burnout_source_o,
    output logic [1:0] input_bias_apply_o,
    output logic [2:0] system_monitor_select_o,
    output logic [2:0] effective_gain_o,
    output logic [10:0] output_rate_sps_o,
    output logic [23:0] offset_coefficient_o,
    output logic [23:0] fullscale_coefficient_o,
    output logic combined_pin_mode_o,
    output logic conversion_ready_pin_o,
    output logic combined_output_pin_o,
    output logic combined_output_oe_o
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The revision field is four bits wide; the value is arbitrary.
    if (REVISION_FIELD < 0 || REVISION_FIELD > 15) begin : g_bad_rev
        $error("REVISION_FIELD must fit in four bits");
    end

    localparam logic [3:0] REVISION_BITS = REVISION_FIELD[3:0];

    // ------------------------------------------------------------------
    // Reset release and pin synchroniser
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;
    logic osc_meta_q;
    logic osc_sync_q;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            osc_meta_q <= 1'b0;
            osc_sync_q <= 1'b0;
        end else begin
            osc_meta_q <= oscillator_external_i;
            osc_sync_q <= osc_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [1:0] burnout_level_q;
    logic [1:0] bias_q;
    logic [2:0] monitor_q;
    logic [2:0] gain_q;
    logic [3:0] rate_q;
    logic [23:0] offset_q;
    logic [23:0] fullscale_q;
    logic mode_q;
    logic wr_burnout;
    logic wr_gain;
    logic gain_change;

    assign wr_burnout = reg_wr_i && (reg_addr_i == ADDR_BURNOUT);
    assign wr_gain = reg_wr_i && (reg_addr_i == ADDR_GAIN_RATE);
    assign gain_change = wr_gain && (reg_wdata_i[6:4] != gain_q);

    // Fixed low bits are not stored; they read back as the pattern.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            burnout_level_q <= BURNOUT_LEVEL_RESET;
        end else if (wr_burnout) begin
            burnout_level_q <= reg_wdata_i[7:6];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            bias_q <= BIAS_RESET;
        end else if (reg_wr_i && reg_addr_i == ADDR_BIAS) begin
            bias_q <= reg_wdata_i[1:0];
        end
    end

    // Bit 7 comes from the oscillator pin, so a write cannot touch it.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            monitor_q <= MONITOR_RESET;
        end else if (reg_wr_i && reg_addr_i == ADDR_MONITOR) begin
            monitor_q <= reg_wdata_i[2:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            gain_q <= GAIN_RESET;
            rate_q <= RATE_RESET;
        end else if (wr_gain) begin
            gain_q <= reg_wdata_i[6:4];
            rate_q <= reg_wdata_i[3:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            offset_q <= OFFSET_RESET;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_OFFSET_LOW: offset_q[7:0] <= reg_wdata_i;
                ADDR_OFFSET_MID: offset_q[15:8] <= reg_wdata_i;
                ADDR_OFFSET_HIGH: offset_q[23:16] <= reg_wdata_i;
                default: offset_q <= offset_q;
            endcase
        end
    end

    // A write of the same gain keeps any calibrated full-scale value.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            fullscale_q <= FULLSCALE_TRIM[GAIN_RESET];
        end else if (gain_change) begin
            fullscale_q <= FULLSCALE_TRIM[reg_wdata_i[6:4]];
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_FULLSCALE_LOW: fullscale_q[7:0] <= reg_wdata_i;
                ADDR_FULLSCALE_MID: fullscale_q[15:8] <= reg_wdata_i;
                ADDR_FULLSCALE_HIGH: fullscale_q[23:16] <= reg_wdata_i;
                default: fullscale_q <= fullscale_q;
            endcase
        end
    end

    // Revision bits are a constant; only the pin mode bit is stored.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == ADDR_REVISION) begin
            mode_q <= reg_wdata_i[3];
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    logic [7:0] rdata_d;

    always_comb begin
        case (reg_addr_i)
            ADDR_BURNOUT: rdata_d = {burnout_level_q, BURNOUT_FIXED_BITS};
            ADDR_BIAS: rdata_d = {6'h00, bias_q};
            ADDR_MONITOR: rdata_d = {osc_sync_q, 4'h0, monitor_q};
            ADDR_GAIN_RATE: rdata_d = {1'b0, gain_q, rate_q};
            ADDR_OFFSET_LOW: rdata_d = offset_q[7:0];
            ADDR_OFFSET_MID: rdata_d = offset_q[15:8];
            ADDR_OFFSET_HIGH: rdata_d = offset_q[23:16];
            ADDR_FULLSCALE_LOW: rdata_d = fullscale_q[7:0];
            ADDR_FULLSCALE_MID: rdata_d = fullscale_q[15:8];
            ADDR_FULLSCALE_HIGH: rdata_d = fullscale_q[23:16];
            ADDR_REVISION: rdata_d = {REVISION_BITS, mode_q, 3'h0};
            default: rdata_d = UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // Decoded controls toward the analog front end
    // ------------------------------------------------------------------
    logic monitor_forces_gain;

    assign monitor_forces_gain = (monitor_q == MON_REFERENCE) ||
        (monitor_q == MON_TEMPERATURE);

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            burnout_enable_o <= 1'b0;
            burnout_source_o <= 3'h0;
        end else begin
            burnout_enable_o <= (burnout_level_q != BURNOUT_OFF);
            burnout_source_o <= {burnout_level_q == BURNOUT_TEN_UA,
                burnout_level_q == BURNOUT_TWO_UA,
                burnout_level_q == BURNOUT_HALF_UA};
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            input_bias_apply_o <= 2'h0;
            system_monitor_select_o <= MONITOR_RESET;
        end else begin
            system_monitor_select_o <= monitor_q;
            input_bias_apply_o <= (monitor_q == MON_NORMAL) ?
                bias_q : 2'h0;
        end
    end

    // The forced gain is not written back, so leaving the monitor mode
    // restores the stored selection with no host action.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            effective_gain_o <= GAIN_RESET;
        end else begin
            effective_gain_o <= monitor_forces_gain ?
                GAIN_ONE_CODE : gain_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            output_rate_sps_o <= RATE_SPS[0];
        end else if (rate_q > RATE_LAST_TABLE_CODE) begin
            output_rate_sps_o <= RATE_SPS_MAX;
        end else begin
            output_rate_sps_o <= RATE_SPS[rate_q];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            offset_coefficient_o <= OFFSET_RESET;
            fullscale_coefficient_o <= FULLSCALE_TRIM[GAIN_RESET];
            combined_pin_mode_o <= 1'b0;
        end else begin
            offset_coefficient_o <= offset_q;
            fullscale_coefficient_o <= fullscale_q;
            combined_pin_mode_o <= mode_q;
        end
    end

    // ------------------------------------------------------------------
    // Ready signalling: channel 0 dedicated pin, channel 1 combined pin
    // ------------------------------------------------------------------
    ready_state_t ready_q [2];
    logic [1:0] ready_active;

    assign ready_active = {mode_q, 1'b1};

    for (genvar ch = 0; ch < 2; ch++) begin : g_ready
        // A new conversion beats a release arriving in the same cycle.
        always_ff @(posedge clk_i or negedge rst_n_q) begin
            if (!rst_n_q) begin
                ready_q[ch] <= READY_HIGH;
            end else if (!ready_active[ch]) begin
                ready_q[ch] <= READY_HIGH;
            end else begin
                case (ready_q[ch])
                    READY_HIGH: begin
                        if (conversion_done_i) begin
                            ready_q[ch] <= READY_LOW;
                        end
                    end
                    READY_LOW: begin
                        if (conversion_done_i) begin
                            ready_q[ch] <= READY_PULSE;
                        end else if (ready_release_i[ch]) begin
                            ready_q[ch] <= READY_HIGH;
                        end
                    end
                    READY_PULSE: begin
                        ready_q[ch] <= READY_LOW;
                    end
                    default: ready_q[ch] <= READY_HIGH;
                endcase
            end
        end
    end

    // The dedicated pin keeps signalling whatever the pin mode bit says.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            conversion_ready_pin_o <= 1'b1;
            combined_output_pin_o <= 1'b1;
            combined_output_oe_o <= 1'b0;
        end else begin
            conversion_ready_pin_o <= (ready_q[0] != READY_LOW);
            combined_output_oe_o <= chip_select_active_i;
            if (mode_q && !shift_active_i) begin
                combined_output_pin_o <= (ready_q[1] != READY_LOW);
            end else begin
                combined_output_pin_o <= serial_data_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_burnout_decode;
        @(posedge clk_i) disable iff (!rst_n_q)
        wr_burnout ##1 1'b1 |=> burnout_enable_o ==
            ($past(reg_wdata_i[7:6], 2) != BURNOUT_OFF);
    endproperty
    a_burnout_decode: assert property (p_burnout_decode)
        else $error("burnout enable does not follow written level");

    property p_bias_override;
        @(posedge clk_i) disable iff (!rst_n_q)
        (monitor_q != MON_NORMAL) |=> input_bias_apply_o == 2'h0;
    endproperty
    a_bias_override: assert property (p_bias_override)
        else $error("bias applied while a monitor routing is active");

    property p_bias_apply;
        @(posedge clk_i) disable iff (!rst_n_q)
        (monitor_q == MON_NORMAL) |=> input_bias_apply_o == $past(bias_q);
    endproperty
    a_bias_apply: assert property (p_bias_apply)
        else $error("bias enables not applied in normal routing");

    property p_osc_flag;
        @(posedge clk_i) disable iff (!rst_n_q)
        reg_rd_i && reg_addr_i == ADDR_MONITOR |=>
            reg_rvalid_o && reg_rdata_o[7] == $past(osc_sync_q);
    endproperty
    a_osc_flag: assert property (p_osc_flag)
        else $error("oscillator flag read back wrong");

    property p_gain_forced;
        @(posedge clk_i) disable iff (!rst_n_q)
        monitor_forces_gain [*2] |-> effective_gain_o == GAIN_ONE_CODE;
    endproperty
    a_gain_forced: assert property (p_gain_forced)
        else $error("gain not forced to one in monitor mode");

    property p_gain_restored;
        @(posedge clk_i) disable iff (!rst_n_q)
        !monitor_forces_gain |=> effective_gain_o == $past(gain_q);
    endproperty
    a_gain_restored: assert property (p_gain_restored)
        else $error("stored gain not applied");

    property p_rate_top;
        @(posedge clk_i) disable iff (!rst_n_q)
        wr_gain && reg_wdata_i[3:0] > RATE_LAST_TABLE_CODE |-> ##2
            output_rate_sps_o == RATE_SPS_MAX;
    endproperty
    a_rate_top: assert property (p_rate_top)
        else $error("high rate codes must select the top rate");

    property p_offset_low;
        @(posedge clk_i) disable iff (!rst_n_q)
        reg_wr_i && reg_addr_i == ADDR_OFFSET_LOW |-> ##2
            offset_coefficient_o[7:0] == $past(reg_wdata_i, 2);
    endproperty
    a_offset_low: assert property (p_offset_low)
        else $error("offset low byte not placed in bits 7:0");

    property p_trim_reload;
        @(posedge clk_i) disable iff (!rst_n_q)
        gain_change |=>
            fullscale_q == FULLSCALE_TRIM[$past(reg_wdata_i[6:4])];
    endproperty
    a_trim_reload: assert property (p_trim_reload)
        else $error("full-scale trim not reloaded on gain change");

    property p_revision_ro;
        @(posedge clk_i) disable iff (!rst_n_q)
        reg_rd_i && reg_addr_i == ADDR_REVISION |=>
            reg_rdata_o[7:4] == REVISION_BITS;
    endproperty
    a_revision_ro: assert property (p_revision_ro)
        else $error("revision field changed");

    property p_pulse_then_low;
        @(posedge clk_i) disable iff (!rst_n_q)
        mode_q && ready_q[1] == READY_LOW && conversion_done_i ##1 mode_q
            |-> ready_q[1] == READY_PULSE ##1 ready_q[1] == READY_LOW;
    endproperty
    a_pulse_then_low: assert property (p_pulse_then_low)
        else $error("combined pin missed its high pulse");

    property p_data_only;
        @(posedge clk_i) disable iff (!rst_n_q)
        !mode_q |=> combined_output_pin_o == $past(serial_data_i);
    endproperty
    a_data_only: assert property (p_data_only)
        else $error("combined pin not data-only with mode clear");

endmodule : adc_config_register_bank

`default_nettype wire

// File: hw/adc_config_pkg.sv
`default_nettype none

package adc_config_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_BURNOUT = 4'h0;
    localparam logic [3:0] ADDR_BIAS = 4'h1;
    localparam logic [3:0] ADDR_MONITOR = 4'h2;
    localparam logic [3:0] ADDR_GAIN_RATE = 4'h3;
    localparam logic [3:0] ADDR_OFFSET_LOW = 4'h4;
    localparam logic [3:0] ADDR_OFFSET_MID = 4'h5;
    localparam logic [3:0] ADDR_OFFSET_HIGH = 4'h6;
    localparam logic [3:0] ADDR_FULLSCALE_LOW = 4'h7;
    localparam logic [3:0] ADDR_FULLSCALE_MID = 4'h8;
    localparam logic [3:0] ADDR_FULLSCALE_HIGH = 4'h9;
    localparam logic [3:0] ADDR_REVISION = 4'hA;

    // ------------------------------------------------------------------
    // Fixed bit patterns and reset values
    // ------------------------------------------------------------------
    localparam logic [5:0] BURNOUT_FIXED_BITS = 6'h01;
    localparam logic [1:0] BURNOUT_LEVEL_RESET = 2'h0;
    localparam logic [1:0] BIAS_RESET = 2'h0;
    localparam logic [2:0] MONITOR_RESET = 3'h0;
    localparam logic [2:0] GAIN_RESET = 3'h0;
    localparam logic [3:0] RATE_RESET = 4'h0;
    localparam logic [23:0] OFFSET_RESET = 24'h000000;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------------
    // Field codes
    // ------------------------------------------------------------------
    localparam logic [1:0] BURNOUT_OFF = 2'h0;
    localparam logic [1:0] BURNOUT_HALF_UA = 2'h1;
    localparam logic [1:0] BURNOUT_TWO_UA = 2'h2;
    localparam logic [1:0] BURNOUT_TEN_UA = 2'h3;
    localparam logic [2:0] MON_NORMAL = 3'h0;
    localparam logic [2:0] MON_OFFSET = 3'h1;
    localparam logic [2:0] MON_REFERENCE = 3'h2;
    localparam logic [2:0] MON_TEMPERATURE = 3'h3;
    localparam logic [2:0] GAIN_ONE_CODE = 3'h0;

    // ------------------------------------------------------------------
    // Output rate table in samples per second
    // ------------------------------------------------------------------
    localparam logic [3:0] RATE_LAST_TABLE_CODE = 4'h8;
    localparam logic [10:0] RATE_SPS_MAX = 11'h7D0;
    localparam logic [10:0] RATE_SPS [9] = '{11'h005, 11'h00A, 11'h014,
        11'h028, 11'h050, 11'h0A0, 11'h140, 11'h280, 11'h3E8};

    typedef enum logic [1:0] {
        READY_HIGH = 2'b00,
        READY_LOW = 2'b01,
        READY_PULSE = 2'b10
    } ready_state_t;

endpackage : adc_config_pkg

`default_nettype wire

// File: dv/host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// Host side of the register port
// ---------------------------------------------------------------
module host_model (
    input wire logic clk_i,
    input wire logic rvalid_i,
    input wire logic [7:0] rdata_i,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0,
    output logic [3:0] addr_o = 4'h0,
    output logic [7:0] wdata_o = 8'h00
);
    // Fixed bits are always sent as their pattern; read-only bits are not.
    function automatic logic [7:0] legal(input logic [3:0] a,
        input logic [7:0] d);
        case (a)
            4'h0: legal = {d[7:6], 6'h01};
            4'h1: legal = {6'h00, d[1:0]};
            4'h2: legal = {d[7], 4'h0, d[2:0]};
            4'h3: legal = {1'b0, d[6:0]};
            4'hA: legal = {d[7:3], 3'h0};
            default: legal = d;
        endcase
    endfunction : legal
    task automatic write(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk_i);
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = legal(a, d);
        @(negedge clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~wdata_o;
    endtask : write
    task automatic read(input logic [3:0] a, output logic [7:0] d,
        output logic v);
        @(negedge clk_i);
        rd_o = 1'b1;
        addr_o = a;
        @(negedge clk_i);
        v = rvalid_i;
        d = rdata_i;
        rd_o = 1'b0;
        addr_o = ~a;
    endtask : read
endmodule : host_model
`default_nettype wire

// File: dv/adc_config_register_bank_tb.sv
`timescale 1ns/100ps
`default_nettype none
module adc_config_register_bank_tb
    import adc_config_pkg::*;
;
    // ---------------------------------------------------------------
    // Stimulus, model and checks
    // ---------------------------------------------------------------
    localparam int REV = 9; // Arbitrary revision value.
    function automatic logic [7:0][23:0] mk_trim();
        for (int g = 0; g < 8; g++) mk_trim[g] = 24'h400000 + 24'h010101 * 24'(g);
    endfunction : mk_trim
    // Distinct trims per gain expose a reload from the wrong slot.
    localparam logic [7:0][23:0] TRIM = mk_trim();
    int sps_tab [9] = '{5, 10, 20, 40, 80, 160, 320, 640, 1000};
    int lvl = 0, bias = 0, mon = 0, gain = 0, rate = 0, mode = 0, ofs = 0;
    int fs = TRIM[0], st0 = 0, st1 = 0, seed = 57, cycles = 0;
    int failures = 0, n_checks = 0, a;
    logic clk_i = 1'b0, arst_n_i = 1'b0, osc = 1'b0, done = 1'b0;
    logic sdat = 1'b0, shift = 1'b0, cs = 1'b0, go = 1'b0, quiet = 1'b0;
    logic chk_comb = 1'b0, pin0_e = 1'b1, comb_e = 1'b1, oe_e = 1'b0;
    logic [1:0] rel = 2'h0, bias_ap;
    logic [7:0] rdata, wdata, d;
    logic [3:0] addr;
    logic [2:0] b_src, mon_o, gain_o;
    logic [10:0] sps_o;
    logic [23:0] ofs_o, fs_o;
    logic wr, rd, rvalid, b_en, mode_o, rdy_o, comb_o, oe_o;
    always #50 clk_i = ~clk_i;
    adc_config_register_bank #(.REVISION_FIELD(REV), .FULLSCALE_TRIM(TRIM))
    i_adc_config_register_bank (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .oscillator_external_i(osc), .conversion_done_i(done),
        .ready_release_i(rel), .serial_data_i(sdat),
        .shift_active_i(shift), .chip_select_active_i(cs),
        .burnout_enable_o(b_en), .burnout_source_o(b_src),
        .input_bias_apply_o(bias_ap), .system_monitor_select_o(mon_o),
        .effective_gain_o(gain_o), .output_rate_sps_o(sps_o),
        .offset_coefficient_o(ofs_o), .fullscale_coefficient_o(fs_o),
        .combined_pin_mode_o(mode_o), .conversion_ready_pin_o(rdy_o),
        .combined_output_pin_o(comb_o), .combined_output_oe_o(oe_o));
    host_model i_host_model (.clk_i(clk_i), .rvalid_i(rvalid),
        .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr),
        .wdata_o(wdata));
    task automatic cmp(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : cmp
    task automatic complete_run();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    // States: 0 ready high, 1 ready low, 2 one-cycle high pulse.
    function automatic int nxt(input int s, input logic dn, input logic rl);
        if (dn) return (s == 1) ? 2 : 1;
        if (s == 2) return 1;
        return (s == 1 && rl) ? 0 : s;
    endfunction : nxt
    always @(posedge clk_i) begin
        oe_e <= cs;
        pin0_e <= (st0 != 1);
        comb_e <= (mode == 0 || shift) ? sdat : (st1 != 1);
        st0 <= nxt(st0, done, rel[0]);
        st1 <= (mode == 0) ? 0 : nxt(st1, done, rel[1]);
        cycles++;
        if (cycles == 10000) begin
            failures++;
            complete_run();
        end
    end
    // Done is never repeated on adjacent cycles, so it cannot hit a pulse.
    always @(negedge clk_i) begin
        done <= go && !quiet && ($random(seed) & 7) == 0 && !done;
        rel <= (go && !quiet) ? 2'($random(seed)) & 2'($random(seed)) : 2'h0;
        sdat <= 1'($random(seed));
        shift <= 1'($random(seed));
        cs <= go && 1'($random(seed));
        if (go) begin
            cmp(rdy_o === pin0_e, "ready pin");
            cmp(oe_o === oe_e, "drive enable");
            if (chk_comb) cmp(comb_o === comb_e, "combined pin");
        end
    end
    task automatic upd(input int a, input int d);
        int sh;
        sh = 8 * ((a - 4) % 3);
        case (a)
            0: lvl = d >> 6;
            1: bias = d & 3;
            2: mon = d & 7;
            3: begin
                if (((d >> 4) & 7) != gain) fs = TRIM[(d >> 4) & 7];
                gain = (d >> 4) & 7;
                rate = d & 15;
            end
            4, 5, 6: ofs = (ofs & ~(255 << sh)) | (d << sh);
            7, 8, 9: fs = (fs & ~(255 << sh)) | (d << sh);
            10: mode = (d >> 3) & 1;
            default: ;
        endcase
    endtask : upd
    function automatic int exp_rd(input int a);
        int sh;
        sh = 8 * ((a - 4) % 3);
        case (a)
            0: return (lvl << 6) | 1;
            1: return bias;
            2: return (int'(osc) << 7) | mon;
            3: return (gain << 4) | rate;
            4, 5, 6: return (ofs >> sh) & 255;
            7, 8, 9: return (fs >> sh) & 255;
            10: return ((REV & 15) << 4) | (mode << 3);
            default: return 0;
        endcase
    endfunction : exp_rd
    task automatic rdchk(input int a);
        logic [7:0] d;
        logic v;
        i_host_model.read(4'(a), d, v);
        cmp(v === 1'b1, "no read valid");
        cmp(d === 8'(exp_rd(a)), "read data");
    endtask : rdchk
    task automatic chk_out();
        cmp(b_en === (lvl != 0), "burnout enable");
        cmp(b_src === 3'((lvl == 0) ? 0 : 1 << (lvl - 1)), "source");
        cmp(bias_ap === 2'((mon == 0) ? bias : 0), "bias");
        cmp(mon_o === 3'(mon), "monitor");
        cmp(gain_o === 3'((mon == 2 || mon == 3) ? 0 : gain), "gain");
        cmp(sps_o === 11'((rate > 8) ? 2000 : sps_tab[rate]), "rate");
        cmp(ofs_o === 24'(ofs), "offset");
        cmp(fs_o === 24'(fs), "fullscale");
        cmp(mode_o === 1'(mode), "pin mode");
    endtask : chk_out
    task automatic set_mode(input logic [7:0] v, input int n);
        quiet = 1'b1;
        i_host_model.write(ADDR_REVISION, v);
        upd(10, v);
        repeat (3) @(negedge clk_i);
        quiet = 1'b0;
        chk_comb = 1'b1;
        repeat (n) @(negedge clk_i);
        chk_comb = 1'b0;
    endtask : set_mode
    initial begin
        repeat (16) @(negedge clk_i);
        arst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        go = 1'b1;
        chk_out();
        for (int i = 0; i < 16; i++) rdchk(i);
        repeat (300) begin
            osc = 1'($random(seed));
            repeat (4) @(negedge clk_i);
            a = $random(seed) & 15;
            d = 8'($random(seed));
            i_host_model.write(4'(a), d);
            upd(a, int'(d));
            @(negedge clk_i);
            chk_out();
            rdchk(a);
        end
        set_mode(8'h00, 40);
        set_mode(8'h08, 80);
        complete_run();
    end
endmodule : adc_config_register_bank_tb
`default_nettype wire
